// ==== core/clk_gate_pkg.sv ====
// package: register map, field layout and bus carriers of the clock gate bank
`default_nettype none

package clk_gate_pkg;

    // -------------------------------------------------------------------
    // bus geometry
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned NUM_UNITS = 8;

    // -------------------------------------------------------------------
    // register offsets within the system control block
    // -------------------------------------------------------------------
    localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
    localparam logic [ADDR_W-1:0] OFF_RUN_CFG = 12'h060;
    localparam logic [ADDR_W-1:0] OFF_RUN_GATE = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_GATE = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_DEEP_GATE = 12'h124;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h204;

    // -------------------------------------------------------------------
    // gate field positions, shared by the three banks and the irq regs
    // -------------------------------------------------------------------
    localparam int unsigned POS_CMP1 = 25;
    localparam int unsigned POS_CMP0 = 24;
    localparam int unsigned POS_TMR2 = 18;
    localparam int unsigned POS_TMR1 = 17;
    localparam int unsigned POS_TMR0 = 16;
    localparam int unsigned POS_SYNC_SERIAL_ZERO_CLK_GATE = 4;
    localparam int unsigned POS_ASY1 = 1;
    localparam int unsigned POS_ASY0 = 0;

    // unit index i of the unit ports sits at bit UNIT_POS[i] of a register
    localparam int unsigned UNIT_POS [NUM_UNITS] = '{
        POS_ASY0, POS_ASY1, POS_SYNC_SERIAL_ZERO_CLK_GATE, POS_TMR0,
        POS_TMR1, POS_TMR2, POS_CMP0, POS_CMP1
    };

    localparam logic [DATA_W-1:0] GATE_MASK = 32'h0307_0013;
    localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0000;
    localparam int unsigned POS_AUTO_GATE = 27;
    localparam logic [DATA_W-1:0] CFG_MASK = 32'h0800_0000;
    localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] IRQ_RESET = 32'h0000_0000;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP = 2'b10
    } power_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [STRB_W-1:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

endpackage : clk_gate_pkg

`default_nettype wire

// ==== core/deep_sleep_clock_gate_bank_one.sv ====
// apb clock gate bank: run, sleep and deep-sleep gates with fault reporting
`default_nettype none

module deep_sleep_clock_gate_bank_one
    import clk_gate_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    input wire power_mode_t power_mode,
    input wire logic [NUM_UNITS-1:0] unit_access,
    output logic [NUM_UNITS-1:0] unit_fault,
    output logic [NUM_UNITS-1:0] unit_clk_en,
    output logic irq
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] run_gate;
        logic [DATA_W-1:0] sleep_gate;
        logic [DATA_W-1:0] deep_gate;
        logic [DATA_W-1:0] run_cfg;
        logic [DATA_W-1:0] clk_on;
        logic [DATA_W-1:0] irq_stat;
        logic [DATA_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic rd_err;
        logic loaded;
    } state_t;

    localparam state_t STATE_RESET = '{
        run_gate: GATE_RESET,
        sleep_gate: GATE_RESET,
        deep_gate: GATE_RESET,
        run_cfg: CFG_RESET,
        clk_on: GATE_RESET,
        irq_stat: IRQ_RESET,
        irq_mask: IRQ_RESET,
        rdata: 32'h0000_0000,
        rd_err: 1'b0,
        loaded: 1'b0
    };

    state_t st_q;
    state_t st_d;

    // -------------------------------------------------------------------
    // decoding helpers
    // -------------------------------------------------------------------
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        return addr[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction : hit

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        return hit(addr, OFF_RUN_CFG) || hit(addr, OFF_RUN_GATE)
            || hit(addr, OFF_SLEEP_GATE) || hit(addr, OFF_DEEP_GATE)
            || hit(addr, OFF_IRQ_STAT) || hit(addr, OFF_IRQ_MASK);
    endfunction : is_mapped

    // merge write data into old value lane by lane, keeping only the
    // bits that the register really implements
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [STRB_W-1:0] strb,
        input logic [DATA_W-1:0] mask
    );
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction : merge

    // -------------------------------------------------------------------
    // bank selection
    // -------------------------------------------------------------------
    logic [DATA_W-1:0] active_bank;

    gate_bank_select u_select (
        .run_bank(st_q.run_gate),
        .sleep_bank(st_q.sleep_gate),
        .deep_bank(st_q.deep_gate),
        .mode(power_mode),
        .auto_gate(st_q.run_cfg[POS_AUTO_GATE]),
        .active_bank(active_bank)
    );

    // -------------------------------------------------------------------
    // per-unit clock enables and fault answers
    // -------------------------------------------------------------------
    logic [DATA_W-1:0] fault_evt;

    generate
        for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
            assign unit_clk_en[i] = st_q.clk_on[UNIT_POS[i]];
            // the fault uses the registered enable, so it agrees with the
            // clock the unit actually sees in this cycle
            assign unit_fault[i] = unit_access[i]
                                   & ~st_q.clk_on[UNIT_POS[i]];
        end
    endgenerate

    always_comb begin
        fault_evt = '0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            fault_evt[UNIT_POS[i]] = unit_fault[i];
        end
    end

    // -------------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (hit(apb_req.paddr, OFF_RUN_CFG)) begin
            rd_mux = st_q.run_cfg;
        end else if (hit(apb_req.paddr, OFF_RUN_GATE)) begin
            rd_mux = st_q.run_gate;
        end else if (hit(apb_req.paddr, OFF_SLEEP_GATE)) begin
            rd_mux = st_q.sleep_gate;
        end else if (hit(apb_req.paddr, OFF_DEEP_GATE)) begin
            rd_mux = st_q.deep_gate;
        end else if (hit(apb_req.paddr, OFF_IRQ_STAT)) begin
            rd_mux = st_q.irq_stat;
        end else if (hit(apb_req.paddr, OFF_IRQ_MASK)) begin
            rd_mux = st_q.irq_mask;
        end
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    logic access_done;
    logic do_write;
    logic [DATA_W-1:0] w1c;

    assign access_done = apb_req.psel & apb_req.penable & st_q.loaded;
    assign do_write = access_done & apb_req.pwrite & ~st_q.rd_err;

    always_comb begin
        st_d = st_q;
        w1c = '0;
        if (clk_en) begin
            // setup cycle: capture the answer so prdata leaves a flop;
            // costs no wait state, as it fits in the setup cycle, and keeps the bus timing
            // independent of the decode depth
            if (apb_req.psel && !st_q.loaded) begin
                st_d.loaded = 1'b1;
                st_d.rdata = rd_mux;
                st_d.rd_err = ~is_mapped(apb_req.paddr);
            end else if (access_done) begin
                st_d.loaded = 1'b0;
            end
            if (do_write) begin
                if (hit(apb_req.paddr, OFF_RUN_CFG)) begin
                    st_d.run_cfg = merge(st_q.run_cfg, apb_req.pwdata,
                                         apb_req.pstrb, CFG_MASK);
                end
                if (hit(apb_req.paddr, OFF_RUN_GATE)) begin
                    st_d.run_gate = merge(st_q.run_gate, apb_req.pwdata,
                                          apb_req.pstrb, GATE_MASK);
                end
                if (hit(apb_req.paddr, OFF_SLEEP_GATE)) begin
                    st_d.sleep_gate = merge(st_q.sleep_gate, apb_req.pwdata,
                                            apb_req.pstrb, GATE_MASK);
                end
                if (hit(apb_req.paddr, OFF_DEEP_GATE)) begin
                    // reserved positions are masked off on the way in
                    st_d.deep_gate = merge(st_q.deep_gate, apb_req.pwdata,
                                           apb_req.pstrb, GATE_MASK);
                end
                if (hit(apb_req.paddr, OFF_IRQ_MASK)) begin
                    st_d.irq_mask = merge(st_q.irq_mask, apb_req.pwdata,
                                          apb_req.pstrb, GATE_MASK);
                end
                if (hit(apb_req.paddr, OFF_IRQ_STAT)) begin
                    w1c = merge('0, apb_req.pwdata, apb_req.pstrb, GATE_MASK);
                end
            end
            // a fault in the clearing cycle survives the clear
            st_d.irq_stat = ((st_q.irq_stat & ~w1c) | fault_evt) & GATE_MASK;
            // no unit runs until software sets its bit
            st_d.clk_on = active_bank & GATE_MASK;
        end
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    always_comb begin
        apb_rsp.pready = access_done & clk_en;
        apb_rsp.pslverr = access_done & clk_en & st_q.rd_err;
        apb_rsp.prdata = st_q.rdata;
    end

    assign irq = |(st_q.irq_stat & st_q.irq_mask);

endmodule : deep_sleep_clock_gate_bank_one

`default_nettype wire

// ==== core/gate_bank_select.sv ====
// bank selector: picks the gate bank that governs the unit clocks now
`default_nettype none

module gate_bank_select
    import clk_gate_pkg::*;
(
    input wire logic [DATA_W-1:0] run_bank,
    input wire logic [DATA_W-1:0] sleep_bank,
    input wire logic [DATA_W-1:0] deep_bank,
    input wire power_mode_t mode,
    input wire logic auto_gate,
    output logic [DATA_W-1:0] active_bank
);

    // -------------------------------------------------------------------
    // selection
    // -------------------------------------------------------------------
    always_comb begin
        active_bank = run_bank;
        if (auto_gate) begin
            case (mode)
                MODE_RUN: active_bank = run_bank;
                MODE_SLEEP: active_bank = sleep_bank;
                MODE_DEEP: active_bank = deep_bank;
                // unknown mode code falls back to the run bank
                default: active_bank = run_bank;
            endcase
        end
    end

endmodule : gate_bank_select

`default_nettype wire

// ==== testbench/clk_gate_props.sv ====
// checker: port relations of the clock gate bank
`default_nettype none

module clk_gate_props
    import clk_gate_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire power_mode_t power_mode,
    input wire logic [NUM_UNITS-1:0] unit_access,
    input wire logic [NUM_UNITS-1:0] unit_fault,
    input wire logic [NUM_UNITS-1:0] unit_clk_en,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // shadow registers rebuilt from completed writes
    // ----
    function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o,
            logic [DATA_W-1:0] m);
        logic [DATA_W-1:0] r;
        r = o;
        for (int b = 0; b < DATA_W; b++)
            if (apb_req.pstrb[b/8] && m[b])
                r[b] = apb_req.pwdata[b];
        return r;
    endfunction : merge

    function automatic logic [NUM_UNITS-1:0] pick(logic [DATA_W-1:0] v);
        for (int i = 0; i < NUM_UNITS; i++)
            pick[i] = v[UNIT_POS[i]];
    endfunction : pick

    logic [DATA_W-1:0] run_q, slp_q, dp_q, cfg_q, msk_q, act;
    logic [1:0] src;
    wire logic [ADDR_W-1:0] a = {apb_req.paddr[ADDR_W-1:2], 2'b00};
    wire logic done = apb_req.psel && apb_req.penable && apb_rsp.pready;
    wire logic wr = done && apb_req.pwrite;
    wire logic rd = done && !apb_req.pwrite;
    wire logic gate_a = a inside {OFF_RUN_GATE, OFF_SLEEP_GATE, OFF_DEEP_GATE};
    wire logic mapped = gate_a || a inside {OFF_RUN_CFG, OFF_IRQ_STAT,
        OFF_IRQ_MASK};
    wire logic [NUM_UNITS-1:0] want = pick(act);
    wire logic [NUM_UNITS-1:0] mskd = pick(msk_q);

    always_comb begin
        src = 2'd0;
        if (cfg_q[POS_AUTO_GATE] && power_mode == MODE_SLEEP)
            src = 2'd1;
        if (cfg_q[POS_AUTO_GATE] && power_mode == MODE_DEEP)
            src = 2'd2;
        act = src == 2'd1 ? slp_q : (src == 2'd2 ? dp_q : run_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= '0;
            slp_q <= '0;
            dp_q <= '0;
            cfg_q <= '0;
            msk_q <= '0;
        end else if (wr) begin
            if (a == OFF_RUN_GATE)
                run_q <= merge(run_q, GATE_MASK);
            if (a == OFF_SLEEP_GATE)
                slp_q <= merge(slp_q, GATE_MASK);
            if (a == OFF_DEEP_GATE)
                dp_q <= merge(dp_q, GATE_MASK);
            if (a == OFF_RUN_CFG)
                cfg_q <= merge(cfg_q, CFG_MASK);
            if (a == OFF_IRQ_MASK)
                msk_q <= merge(msk_q, GATE_MASK);
        end
    end

    // ----
    // properties
    // ----
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_fault_when_gated: assert property (
        unit_fault == (unit_access & ~unit_clk_en))
        else $error("unit fault differs from access and gate");
    a_reset_all_off: assert property (
        $rose(presetn) |-> unit_clk_en == '0 && !irq)
        else $error("unit clock on after reset");
    a_run_bank_gates: assert property (
        clk_en && src == 2'd0 |=> unit_clk_en == $past(want))
        else $error("run bank not applied");
    a_sleep_bank_gates: assert property (
        clk_en && src == 2'd1 ##1 1'b1 |-> unit_clk_en == $past(want))
        else $error("sleep bank not applied");
    a_deep_bank_gates: assert property (
        (clk_en && src == 2'd2) |=> $past(want) == unit_clk_en)
        else $error("deep bank not applied");
    a_reserved_read_zero: assert property (
        rd && gate_a |-> (apb_rsp.prdata & ~GATE_MASK) == '0)
        else $error("reserved gate bit reads one");
    a_deep_read_back: assert property (
        rd && a == OFF_DEEP_GATE |-> apb_rsp.prdata == dp_q)
        else $error("deep gate read differs");
    a_unmapped_error: assert property (
        done |-> apb_rsp.pslverr == !mapped)
        else $error("error response wrong");
    a_fault_raises_irq: assert property (
        clk_en && (unit_fault & mskd) != '0 |=> irq)
        else $error("unmasked fault gave no interrupt");
    a_freeze_holds: assert property (
        !clk_en |=> $stable(unit_clk_en) && $stable(irq))
        else $error("state moved while clock enable low");

    c_deep_active: cover property (src == 2'd2 && unit_clk_en != '0);
    c_fault_seen: cover property (unit_fault != '0);
    c_irq_high: cover property (irq);
    c_unmapped: cover property (done && !mapped);
endmodule : clk_gate_props

bind deep_sleep_clock_gate_bank_one clk_gate_props u_props (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .power_mode(power_mode), .unit_access(unit_access),
    .unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .irq(irq));

`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: register, gating, fault and interrupt scenarios
`default_nettype none

module tb
    import clk_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    power_mode_t mode = MODE_RUN;
    logic [NUM_UNITS-1:0] acc = '0;
    logic [NUM_UNITS-1:0] fault, gate;
    logic irq, err;
    logic [DATA_W-1:0] rd;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [ADDR_W-1:0] offs [6] = '{OFF_RUN_CFG, OFF_RUN_GATE,
        OFF_SLEEP_GATE, OFF_DEEP_GATE, OFF_IRQ_STAT, OFF_IRQ_MASK};

    deep_sleep_clock_gate_bank_one u_dut (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp), .power_mode(mode),
        .unit_access(acc), .unit_fault(fault), .unit_clk_en(gate),
        .irq(irq));

    initial begin
        forever #4 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // a hang is cut short well beyond the roughly 150 cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic cmp(input logic [DATA_W-1:0] got,
            input logic [DATA_W-1:0] x);
        checks++;
        if (got !== x) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, x);
        end
    endtask : cmp

    // ----
    // bus master: hold the request until pready, idle cycle after
    // ----
    task automatic apb(input logic w, input logic [ADDR_W-1:0] ad,
            input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, ad, d, s};
        @(posedge pclk);
        req.penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        cmp(32'(n), 32'h1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic t_reset();
        foreach (offs[i]) begin
            apb(1'b0, offs[i], '0, 4'h0);
            cmp(rd, '0);
        end
        cmp({24'h0, gate}, '0);
    endtask : t_reset

    task automatic t_deep_reg();
        apb(1'b1, OFF_DEEP_GATE, 32'hffff_ffff, 4'hf);
        apb(1'b0, OFF_DEEP_GATE, '0, 4'h0);
        cmp(rd, GATE_MASK);
        apb(1'b1, OFF_DEEP_GATE, '0, 4'h1);
        apb(1'b0, OFF_DEEP_GATE, '0, 4'h0);
        cmp(rd, 32'h0307_0000);
        apb(1'b1, 12'h300, 32'hffff_ffff, 4'hf);
        cmp({31'h0, err}, 32'h1);
    endtask : t_deep_reg

    // one unit at a time; every other unit must fault on access
    task automatic t_unit_map();
        for (int i = 0; i < NUM_UNITS; i++) begin
            apb(1'b1, OFF_RUN_GATE, 32'h1 << UNIT_POS[i], 4'hf);
            repeat (2) @(posedge pclk);
            cmp(32'(gate), 32'h1 << i);
            acc <= '1;
            @(negedge pclk);
            cmp({24'h0, fault}, {24'h0, ~(8'h1 << i)});
            @(posedge pclk);
            acc <= '0;
        end
        cmp({31'h0, irq}, '0);
    endtask : t_unit_map

    task automatic t_modes();
        power_mode_t m [4] = '{MODE_RUN, MODE_SLEEP, MODE_DEEP,
            power_mode_t'(2'b11)};
        logic [7:0] x [4] = '{8'h07, 8'h40, 8'hb0, 8'h07};
        apb(1'b1, OFF_RUN_GATE, 32'h0000_0013, 4'hf);
        apb(1'b1, OFF_SLEEP_GATE, 32'h0100_0000, 4'hf);
        apb(1'b1, OFF_DEEP_GATE, 32'h0206_0000, 4'hf);
        mode <= MODE_DEEP;
        repeat (3) @(posedge pclk);
        cmp({24'h0, gate}, 32'h07);
        apb(1'b1, OFF_RUN_CFG, 32'h0800_0000, 4'hf);
        for (int i = 0; i < 4; i++) begin
            mode <= m[i];
            repeat (3) @(posedge pclk);
            cmp({24'h0, gate}, {24'h0, x[i]});
        end
    endtask : t_modes

    // start from a clean status so only this fault can raise the line
    task automatic t_irq();
        apb(1'b1, OFF_IRQ_STAT, GATE_MASK, 4'hf);
        apb(1'b0, OFF_IRQ_STAT, '0, 4'h0);
        cmp(rd, '0);
        acc <= 8'h08;
        @(posedge pclk);
        acc <= '0;
        repeat (2) @(posedge pclk);
        cmp(32'(irq), '0);
        apb(1'b0, OFF_IRQ_STAT, '0, 4'h0);
        cmp(rd, 32'h0001_0000);
        apb(1'b1, OFF_IRQ_MASK, 32'h0001_0000, 4'hf);
        @(posedge pclk);
        cmp(32'(irq), 32'h1);
        apb(1'b1, OFF_IRQ_STAT, 32'h0001_0000, 4'hf);
        apb(1'b0, OFF_IRQ_STAT, '0, 4'h0);
        cmp(rd, '0);
        cmp(32'(irq), '0);
    endtask : t_irq

    // clock enable low must hold the gates and drop faults meanwhile
    task automatic t_freeze();
        clk_en <= 1'b0;
        mode <= MODE_DEEP;
        acc <= 8'h08;
        repeat (3) @(posedge pclk);
        cmp(32'(gate), 32'h07);
        clk_en <= 1'b1;
        acc <= '0;
        repeat (3) @(posedge pclk);
        cmp(32'(gate), 32'hb0);
        cmp(32'(irq), '0);
        mode <= MODE_RUN;
        repeat (3) @(posedge pclk);
        cmp(32'(gate), 32'h07);
    endtask : t_freeze

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_deep_reg();
        t_unit_map();
        t_modes();
        t_irq();
        t_freeze();
        complete_run();
    end
endmodule : tb

`default_nettype wire
